// [design/swc_pkg.sv]
package swc_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS   = 4'h0;
  localparam logic [3:0] ADDR_CTRL     = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_WAKE_EN  = 4'h4;
  localparam logic [3:0] ADDR_WDT_CNT  = 4'h5;

  // Status register field positions
  localparam int BIT_PD = 3;
  localparam int BIT_TO = 4;

  // Control register field positions
  localparam int BIT_WDT_EN  = 0;
  localparam int BIT_GIE     = 1;
  localparam int BIT_CLR_WDT = 2;

  // Event status bits
  localparam int EV_SLEEP = 0;
  localparam int EV_WAKE  = 1;
  localparam int EV_WDT   = 2;
  localparam int EV_NOP   = 3;
  localparam int EV_W     = 4;

  // Number of peripheral wake sources
  localparam int NUM_PERIPH = 9;

  // Reset values
  localparam logic [7:0]            STATUS_RST  = 8'h18;
  localparam logic [7:0]            CTRL_RST    = 8'h00;
  localparam logic [EV_W-1:0]       MASK_RST    = 4'h0;
  localparam logic [NUM_PERIPH+1:0] WAKE_EN_RST = 11'h000;

  // Interrupt vector
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // Timing
  localparam int  CLK_HZ           = 40_000_000;
  localparam int  WDT_PERIOD_US    = 1000;
  localparam int  WDT_PERIOD_CYC   = (CLK_HZ / 1_000_000) * WDT_PERIOD_US;
  localparam int  OSC_STARTUP_CYC  = 1024;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_ENTER  = 3'b001,
    ST_SLEEP  = 3'b010,
    ST_OSCUP  = 3'b011,
    ST_RESUME = 3'b100
  } swc_state_t;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } swc_bus_t;

  // Resume directive to the core
  typedef struct packed {
    logic        valid;
    logic        toVector;
    logic [12:0] vector;
  } swc_resume_t;

endpackage : swc_pkg

// [design/swc_sync.sv]
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Three-stage synchroniser with agreement on the last two stages
// ---------------------------------------------------------------------------
module swc_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Shift chain
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          dout[g] <= 1'b0;
        end else if (s2_r[g] == s3_r[g]) begin
          dout[g] <= s3_r[g];
        end
      end
    end
  endgenerate

endmodule : swc_sync

// [design/swc_sleep_wake.sv]
`timescale 1ns/1ps

// Summary of operation
// - Sleep instruction enters power-down; watchdog cleared on entry, keeps counting asleep.
// - Entry clears power-down flag bit 3, sets timeout flag bit 4, stops oscillator.
// - Port drive states are frozen as they were before sleep.
// - Wake on master clear, enabled watchdog timeout, or enabled interrupt.
// - Master clear during sleep resets the device; other wakes resume execution.
// - Power-down flag set at power-up; timeout flag cleared by watchdog wake.
// - Only the listed asynchronous peripheral sources may wake the device.
// - Clocked peripherals raise no interrupts while asleep.
// - Instruction at PC plus one is prefetched and runs first after a wake without vector branch.
// - Interrupt wakes only with its enable set, regardless of global enable.
// - Global enable clear resumes after sleep; set branches to vector 0004h at once on an interrupt wake.
// - Enabled interrupt already pending makes sleep a no-operation.
// - Interrupt during or after sleep: complete entry, then wake at once.
module swc_sleep_wake #(
  parameter int          WDT_CYC    = swc_pkg::WDT_PERIOD_CYC,
  parameter int          OSC_CYC    = swc_pkg::OSC_STARTUP_CYC,
  parameter int          PORT_W     = 8,
  parameter int          NPERIPH    = swc_pkg::NUM_PERIPH
) (
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  input  wire logic [3:0]               busAddr,
  input  wire logic [7:0]               busWdata,
  input  wire logic                     busWr,
  input  wire logic                     busRd,
  output logic      [7:0]               busRdata,
  input  wire logic                     sleepExec,
  input  wire logic [12:0]              pcNow,
  input  wire logic                     master_clear_pin_n,
  input  wire logic                     extIntPin,
  input  wire logic                     port_b_pins_chg,
  input  wire logic [NPERIPH-1:0]       periphIrq,
  input  wire logic [NPERIPH-1:0]       periphAsync,
  input  wire logic [PORT_W-1:0]        portOutIn,
  input  wire logic [PORT_W-1:0]        portOeIn,
  output logic      [PORT_W-1:0]        portOut,
  output logic      [PORT_W-1:0]        portOe,
  output logic                          oscDriverOn,
  output logic                          coreHalt,
  output logic                          deviceReset,
  output logic                          resumeValid,
  output logic                          resumeToVector,
  output logic      [12:0]              resumeVector,
  output logic      [12:0]              prefetchAddr,
  output logic                          sleepNop,
  output logic                          wdtClear,
  output logic                          irqOut
);

  localparam int NW = NPERIPH + 2;
  localparam int WDT_W = $clog2(WDT_CYC + 1);
  localparam int OSC_W = $clog2(OSC_CYC + 1);
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYC - 1);
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_CYC - 1);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  swc_pkg::swc_bus_t    bus;
  swc_pkg::swc_state_t  state_r;
  swc_pkg::swc_state_t  state_nxt;
  swc_pkg::swc_resume_t resume;
  logic [7:0]           status_r;
  logic [7:0]           ctrl_r;
  logic [NW-1:0]        wakeEn_r;
  logic [swc_pkg::EV_W-1:0] irqStat_r;
  logic [swc_pkg::EV_W-1:0] irqMask_r;
  logic [swc_pkg::EV_W-1:0] evSet;
  logic [WDT_W-1:0]     wdtCnt_r;
  logic [OSC_W-1:0]     oscCnt_r;
  logic [NW+1:0]        asyncIn;
  logic [NW+1:0]        syncOut;
  logic                 mclrN;
  logic                 mclrSeen_r;
  logic [NW-1:0]        srcs;
  logic                 wakeIrq;
  logic                 wdtTick;
  logic                 wdtEn;
  logic                 global_irq_enable;
  logic                 sleepGo;
  logic                 nopGo;
  logic                 wdtWake_r;

  assign bus = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};
  assign wdtEn = ctrl_r[swc_pkg::BIT_WDT_EN];
  assign global_irq_enable   = ctrl_r[swc_pkg::BIT_GIE];

  // ---------------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------------
  assign asyncIn = {master_clear_pin_n, extIntPin, port_b_pins_chg, periphIrq, 1'b0};

  swc_sync #(
    .W (NW + 2)
  ) u_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     (asyncIn),
    .dout    (syncOut)
  );

  assign mclrN = syncOut[NW+1];

  // Wake source qualification
  function automatic logic [NW-1:0] qualify(
    input logic [NW-1:0]      raw,
    input logic [NPERIPH-1:0] async,
    input logic               asleep
  );
    logic [NW-1:0] q;
    q = raw;
    if (asleep) begin
      q[NPERIPH-1:0] = raw[NPERIPH-1:0] & async;
    end
    return q;
  endfunction : qualify

  always_comb begin
    srcs = qualify(syncOut[NW:1], periphAsync, state_r != swc_pkg::ST_RUN);
  end

  // Individual enables gate every source, global enable does not
  assign wakeIrq = |(srcs & wakeEn_r);

  // Sleep instruction outcome
  assign nopGo   = sleepExec && (state_r == swc_pkg::ST_RUN) && wakeIrq;
  assign sleepGo = sleepExec && (state_r == swc_pkg::ST_RUN) && !wakeIrq;

  // Watchdog timeout tick
  assign wdtTick = wdtEn && (wdtCnt_r == WDT_LAST);

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      swc_pkg::ST_RUN: begin
        if (sleepGo) begin
          state_nxt = swc_pkg::ST_ENTER;
        end
      end
      swc_pkg::ST_ENTER: begin
        state_nxt = swc_pkg::ST_SLEEP;
      end
      swc_pkg::ST_SLEEP: begin
        if (wakeIrq || wdtTick) begin
          state_nxt = swc_pkg::ST_OSCUP;
        end
      end
      swc_pkg::ST_OSCUP: begin
        if (oscCnt_r == OSC_LAST) begin
          state_nxt = swc_pkg::ST_RESUME;
        end
      end
      swc_pkg::ST_RESUME: begin
        state_nxt = swc_pkg::ST_RUN;
      end
      default: begin
        state_nxt = swc_pkg::ST_RUN;
      end
    endcase
  end

  // State register, master clear forces run
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= swc_pkg::ST_RUN;
    end else if (!mclrN) begin
      state_r <= swc_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Oscillator start-up counter
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oscCnt_r <= '0;
    end else if (state_r == swc_pkg::ST_OSCUP) begin
      oscCnt_r <= oscCnt_r + 1'b1;
    end else begin
      oscCnt_r <= '0;
    end
  end

  // Watchdog: cleared on entry or on software clear, runs during sleep
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdtCnt_r <= '0;
    end else if (!wdtEn || sleepGo || (bus.wr && bus.addr == swc_pkg::ADDR_CTRL
                 && bus.wdata[swc_pkg::BIT_CLR_WDT])) begin
      wdtCnt_r <= '0;
    end else if (wdtTick) begin
      wdtCnt_r <= '0;
    end else begin
      wdtCnt_r <= wdtCnt_r + 1'b1;
    end
  end

  // Remember a watchdog-caused wake
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdtWake_r <= 1'b0;
    end else if (state_r == swc_pkg::ST_SLEEP) begin
      wdtWake_r <= wdtTick && !wakeIrq;
    end
  end

  // ---------------------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= swc_pkg::STATUS_RST;
    end else if (sleepGo) begin
      status_r[swc_pkg::BIT_PD] <= 1'b0;
      status_r[swc_pkg::BIT_TO] <= 1'b1;
    end else if (state_r == swc_pkg::ST_SLEEP && wdtTick && !wakeIrq) begin
      status_r[swc_pkg::BIT_TO] <= 1'b0;
    end else if (bus.wr && bus.addr == swc_pkg::ADDR_CTRL && bus.wdata[swc_pkg::BIT_CLR_WDT]) begin
      status_r[swc_pkg::BIT_PD] <= 1'b1;
      status_r[swc_pkg::BIT_TO] <= 1'b1;
    end
  end

  // Control and enable registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r    <= swc_pkg::CTRL_RST;
      wakeEn_r  <= swc_pkg::WAKE_EN_RST;
      irqMask_r <= swc_pkg::MASK_RST;
    end else if (bus.wr) begin
      if (bus.addr == swc_pkg::ADDR_CTRL) begin
        ctrl_r <= bus.wdata & 8'h03;
      end
      if (bus.addr == swc_pkg::ADDR_WAKE_EN) begin
        wakeEn_r <= NW'({3'h0, bus.wdata});
      end
      if (bus.addr == swc_pkg::ADDR_IRQ_MASK) begin
        irqMask_r <= bus.wdata[swc_pkg::EV_W-1:0];
      end
    end
  end

  // Sticky event bits, set wins over write-one-to-clear
  assign evSet = {nopGo, wdtTick & (state_r == swc_pkg::ST_SLEEP),
                  state_r == swc_pkg::ST_RESUME, sleepGo};

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStat_r <= '0;
    end else if (bus.wr && bus.addr == swc_pkg::ADDR_IRQ_STAT) begin
      irqStat_r <= (irqStat_r & ~bus.wdata[swc_pkg::EV_W-1:0]) | evSet;
    end else begin
      irqStat_r <= irqStat_r | evSet;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |((irqStat_r | evSet) & irqMask_r);
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busRdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        swc_pkg::ADDR_STATUS:   busRdata <= status_r;
        swc_pkg::ADDR_CTRL:     busRdata <= ctrl_r;
        swc_pkg::ADDR_IRQ_STAT: busRdata <= 8'(irqStat_r);
        swc_pkg::ADDR_IRQ_MASK: busRdata <= 8'(irqMask_r);
        swc_pkg::ADDR_WAKE_EN:  busRdata <= wakeEn_r[7:0];
        swc_pkg::ADDR_WDT_CNT:  busRdata <= {5'h00, state_r};
        default:                busRdata <= 8'h00;
      endcase
    end else begin
      busRdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Core-facing outputs
  // ---------------------------------------------------------------------------
  assign resume.valid    = state_r == swc_pkg::ST_RESUME;
  assign resume.toVector = global_irq_enable && !wdtWake_r;
  assign resume.vector   = swc_pkg::IRQ_VECTOR;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oscDriverOn    <= 1'b1;
      coreHalt       <= 1'b0;
      deviceReset    <= 1'b1;
      resumeValid    <= 1'b0;
      resumeToVector <= 1'b0;
      resumeVector   <= 13'h0000;
      prefetchAddr   <= 13'h0000;
      sleepNop       <= 1'b0;
      wdtClear       <= 1'b0;
    end else begin
      oscDriverOn    <= state_nxt == swc_pkg::ST_RUN || state_nxt == swc_pkg::ST_OSCUP
                        || state_nxt == swc_pkg::ST_RESUME;
      coreHalt       <= state_nxt != swc_pkg::ST_RUN;
      deviceReset    <= !mclrN;
      resumeValid    <= resume.valid;
      resumeToVector <= resume.valid && resume.toVector;
      resumeVector   <= resume.vector;
      sleepNop       <= nopGo;
      wdtClear       <= sleepGo;
      if (sleepGo) begin
        prefetchAddr <= pcNow + 13'h0001;
      end
    end
  end

  // Port state: frozen at entry, zeroed by master clear, follows core otherwise
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      portOut <= '0;
      portOe  <= '0;
    end else if (!mclrN) begin
      portOut <= '0;
      portOe  <= '0;
    end else if (state_r == swc_pkg::ST_RUN && !sleepGo) begin
      portOut <= portOutIn;
      portOe  <= portOeIn;
    end
  end

endmodule : swc_sleep_wake

// [test/swc_sleep_wake_props.sv]
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Sleep and wake port checker
// ---------------------------------------------------------------------------
module swc_sleep_wake_props #(
  parameter int WDT_CYC = 16,
  parameter int OSC_CYC = 4,
  parameter int PORT_W  = 8,
  parameter int NPERIPH = 9
) (
  input wire logic              sys_clk,
  input wire logic              arst_n,
  input wire logic              sleepExec,
  input wire logic [12:0]       pcNow,
  input wire logic              master_clear_pin_n,
  input wire logic [PORT_W-1:0] portOut,
  input wire logic [PORT_W-1:0] portOe,
  input wire logic              oscDriverOn,
  input wire logic              coreHalt,
  input wire logic              deviceReset,
  input wire logic              resumeValid,
  input wire logic              resumeToVector,
  input wire logic [12:0]       resumeVector,
  input wire logic [12:0]       prefetchAddr,
  input wire logic              sleepNop,
  input wire logic              wdtClear
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_halt_cause;
    $rose(coreHalt) |-> $past(sleepExec);
  endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without sleep");

  property p_entry;
    $rose(coreHalt) |-> wdtClear && !oscDriverOn;
  endproperty
  a_entry: assert property (p_entry) else $error("entry without clear or osc stop");

  property p_frozen;
    coreHalt && $past(coreHalt) && !deviceReset |-> $stable(portOut) && $stable(portOe);
  endproperty
  a_frozen: assert property (p_frozen) else $error("port drive moved asleep");

  property p_prefetch;
    $rose(coreHalt) |-> prefetchAddr == $past(pcNow) + 13'h0001;
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("prefetch address wrong");

  property p_vector;
    resumeToVector |-> resumeValid && resumeVector == 13'h0004;
  endproperty
  a_vector: assert property (p_vector) else $error("vector branch wrong");

  property p_osc;
    resumeValid |-> oscDriverOn && !coreHalt && $past(oscDriverOn, OSC_CYC - 1);
  endproperty
  a_osc: assert property (p_osc) else $error("resume before osc settled");

  property p_release;
    resumeValid |=> !coreHalt && !resumeValid;
  endproperty
  a_release: assert property (p_release) else $error("halt not released");

  property p_nop;
    sleepNop |-> !coreHalt && !wdtClear;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op sleep halted");

  property p_master_clear_pin;
    $fell(master_clear_pin_n) |-> ##[1:6] deviceReset;
  endproperty
  a_master_clear_pin: assert property (p_master_clear_pin) else $error("pin reset missed");

  property p_no_resume;
    deviceReset |-> !resumeValid;
  endproperty
  a_no_resume: assert property (p_no_resume) else $error("resume during reset");
endmodule : swc_sleep_wake_props

// [test/swc_core_model.sv]
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Core model: program counter, sleep issue, port drive
// ---------------------------------------------------------------------------
module swc_core_model (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        goSleep,
  input  wire logic        coreHalt,
  input  wire logic        resumeValid,
  input  wire logic        resumeToVector,
  input  wire logic [12:0] resumeVector,
  input  wire logic [12:0] prefetchAddr,
  output logic             sleepExec,
  output logic      [12:0] pcNow,
  output logic      [7:0]  portOutIn,
  output logic      [7:0]  portOeIn
);
  // Step, issue sleep, jump on resume (branch taken at once)
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sleepExec <= 1'b0;
      pcNow     <= 13'h0100;
    end else begin
      sleepExec <= goSleep && !coreHalt;
      if (resumeValid) begin
        pcNow <= resumeToVector ? resumeVector : prefetchAddr;
      end else if (!coreHalt && !sleepExec) begin
        pcNow <= pcNow + 13'h0001;
      end
    end
  end

  // Core drive keeps toggling while halted
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      portOutIn <= 8'h00;
      portOeIn  <= 8'h00;
    end else if (coreHalt) begin
      portOutIn <= ~portOutIn;
      portOeIn  <= ~portOeIn;
    end else begin
      portOutIn <= pcNow[7:0];
      portOeIn  <= 8'h0f;
    end
  end
endmodule : swc_core_model

// [test/sleep_wake_control_tb.sv]
`timescale 1ns/1ps

module sleep_wake_control_tb;
  logic        sys_clk, arst_n, busWr, busRd, goSleep, sleepExec, master_clear_pin_n;
  logic        extIntPin, port_b_pins_chg, oscDriverOn, coreHalt, deviceReset, irqOut;
  logic        resumeValid, resumeToVector, sleepNop, wdtClear;
  logic [3:0]  busAddr;
  logic [7:0]  busWdata, busRdata, portOutIn, portOeIn, portOut, portOe;
  logic [8:0]  periphIrq, periphAsync;
  logic [12:0] pcNow, resumeVector, prefetchAddr, spc;
  int          fail_count, comparisons;

  // ---------------------------------------------------------------------------
  // Design, core model, clock
  // ---------------------------------------------------------------------------
  swc_sleep_wake #(.WDT_CYC(16), .OSC_CYC(4)) dut (
    .sys_clk, .arst_n, .busAddr, .busWdata, .busWr, .busRd, .busRdata, .sleepExec, .pcNow,
    .master_clear_pin_n, .extIntPin, .port_b_pins_chg, .periphIrq, .periphAsync, .portOutIn,
    .portOeIn, .portOut, .portOe, .oscDriverOn, .coreHalt, .deviceReset, .resumeValid,
    .resumeToVector, .resumeVector, .prefetchAddr, .sleepNop, .wdtClear, .irqOut);

  swc_core_model core (
    .sys_clk, .arst_n, .goSleep, .coreHalt, .resumeValid, .resumeToVector, .resumeVector,
    .prefetchAddr, .sleepExec, .pcNow, .portOutIn, .portOeIn);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    busWr    <= 1'b1;
    busAddr  <= a;
    busWdata <= d;
    @(posedge sys_clk);
    busWr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string what);
    @(posedge sys_clk);
    busRd   <= 1'b1;
    busAddr <= a;
    @(posedge sys_clk);
    busRd   <= 1'b0;
    #1 chk({5'h00, busRdata}, {5'h00, e}, what);
  endtask : rd

  // Sleep issue, optional flag raised with the sleep cycle
  task automatic do_sleep(input logic [8:0] irq);
    @(posedge sys_clk);
    goSleep <= 1'b1;
    @(posedge sys_clk);
    goSleep   <= 1'b0;
    periphIrq <= irq;
    #1 spc = pcNow;
    @(posedge sys_clk);
    #1;
  endtask : do_sleep

  task automatic wait_resume(input logic toVec);
    int n;
    n = 0;
    while (resumeValid !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(resumeValid, 1'b1, "resume");
    chk(resumeToVector, toVec, "vector select");
    @(posedge sys_clk);
    #1 chk(pcNow, toVec ? 13'h0004 : spc + 13'h0001, "resume pc");
  endtask : wait_resume

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("unexpected %0t run too long", $time);
    test_done();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    {busWr, busRd, goSleep, extIntPin, port_b_pins_chg, arst_n} = '0;
    {busAddr, busWdata, periphIrq} = '0;
    master_clear_pin_n = 1'b1;
    periphAsync = 9'h1fd;
    fail_count = 0;
    comparisons = 0;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(deviceReset, 1'b0, "reset release");
    rd(swc_pkg::ADDR_STATUS, 8'h18, "status reset");
    rd(swc_pkg::ADDR_CTRL, 8'h00, "ctrl reset");
    rd(swc_pkg::ADDR_IRQ_MASK, 8'h00, "mask reset");
    rd(4'hf, 8'h00, "unmapped");
    // Enabled async source wakes; others do not
    wr(swc_pkg::ADDR_WAKE_EN, 8'h03);
    do_sleep(9'h000);
    chk(coreHalt, 1'b1, "halted");
    chk(oscDriverOn, 1'b0, "osc off");
    rd(swc_pkg::ADDR_STATUS, 8'h10, "status asleep");
    periphIrq <= 9'h006;
    repeat (20) @(posedge sys_clk);
    #1 chk(coreHalt, 1'b1, "no wake from clocked or disabled source");
    periphIrq <= 9'h007;
    wait_resume(1'b0);
    chk(deviceReset, 1'b0, "no reset on wake");
    periphIrq <= 9'h000;
    // Event status, mask, clear
    rd(swc_pkg::ADDR_IRQ_STAT, 8'h03, "events");
    wr(swc_pkg::ADDR_IRQ_MASK, 8'h01);
    @(posedge sys_clk);
    #1 chk(irqOut, 1'b1, "irq raised");
    wr(swc_pkg::ADDR_IRQ_STAT, 8'h01);
    @(posedge sys_clk);
    #1 chk(irqOut, 1'b0, "irq cleared");
    rd(swc_pkg::ADDR_IRQ_STAT, 8'h02, "event left");
    // Flag during sleep, global enable set
    wr(swc_pkg::ADDR_CTRL, 8'h02);
    do_sleep(9'h001);
    chk(wdtClear, 1'b1, "entry completed");
    wait_resume(1'b1);
    rd(swc_pkg::ADDR_STATUS, 8'h10, "status after entry");
    // Flag pending before sleep
    wr(swc_pkg::ADDR_CTRL, 8'h06);
    repeat (5) @(posedge sys_clk);
    do_sleep(9'h001);
    chk(coreHalt, 1'b0, "no-op sleep");
    rd(swc_pkg::ADDR_STATUS, 8'h18, "flags untouched");
    rd(swc_pkg::ADDR_IRQ_STAT, 8'h0b, "no-op event");
    periphIrq <= 9'h000;
    wr(swc_pkg::ADDR_IRQ_STAT, 8'h0f);
    // Watchdog wake
    wr(swc_pkg::ADDR_CTRL, 8'h03);
    do_sleep(9'h000);
    chk(wdtClear, 1'b1, "wdt cleared");
    wait_resume(1'b0);
    wr(swc_pkg::ADDR_CTRL, 8'h00);
    rd(swc_pkg::ADDR_STATUS, 8'h00, "timeout cause");
    // Pin reset while asleep
    do_sleep(9'h000);
    master_clear_pin_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    #1 chk(deviceReset, 1'b1, "pin reset");
    @(posedge sys_clk);
    master_clear_pin_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 chk(deviceReset, 1'b0, "pin reset released");
    chk(coreHalt, 1'b0, "restarted");
    test_done();
  end
endmodule : sleep_wake_control_tb

bind swc_sleep_wake swc_sleep_wake_props #(
  .WDT_CYC(WDT_CYC), .OSC_CYC(OSC_CYC), .PORT_W(PORT_W), .NPERIPH(NPERIPH)
) u_props (
  .sys_clk, .arst_n, .sleepExec, .pcNow, .master_clear_pin_n, .portOut, .portOe, .oscDriverOn,
  .coreHalt, .deviceReset, .resumeValid, .resumeToVector, .resumeVector, .prefetchAddr,
  .sleepNop, .wdtClear);
